// ### hdl/mcu_mem_defines.vh
/* Memory map and external bus constants.
   Included by bare name from the bus unit design file. */
`ifndef MCU_MEM_DEFINES_VH
`define MCU_MEM_DEFINES_VH

// ----------
// Special register byte addresses
// ----------
`define MM_SFR_PORT0 8'h80
`define MM_SFR_TCTRL 8'h88
`define MM_SFR_PORT1 8'h90
`define MM_SFR_PORT2 8'hA0
`define MM_SFR_IRQEN 8'hA8
`define MM_SFR_PORT3 8'hB0
`define MM_SFR_IRQPRI 8'hB8
`define MM_SFR_SERST 8'hC8
`define MM_SFR_PSW 8'hD0
`define MM_SFR_SERCNT 8'hD8
`define MM_SFR_ACC 8'hE0
`define MM_SFR_AUXB 8'hF0
`define MM_SFR_COUNT 12
`define MM_SFR_NONE 4'hF
`define MM_PORT_RESET 8'hFF
`define MM_SFR_RESET 8'h00

// ----------
// Internal memory layout
// ----------
`define MM_RAM_BYTES 192
`define MM_SFR_AREA_BIT 7
`define MM_BITRAM_BASE 8'h20
`define MM_PSW_BANK_HI 4
`define MM_PSW_BANK_LO 3
`define MM_IM_DIRECT 2'h0
`define MM_IM_INDIRECT 2'h1
`define MM_IM_BIT 2'h2
`define MM_IM_BANKREG 2'h3

// ----------
// Program space and vectors
// ----------
`define MM_ROM_TOP 16'h0FFF
`define MM_VEC_BASE 16'h0003
`define MM_VEC_STRIDE_SHIFT 3
`define MM_VEC_LAST 3'h4

// ----------
// Port 1 and port 3 bit positions
// ----------
`define MM_P1_RTS 6
`define MM_P1_CTS 7
`define MM_P3_SER_RX 0
`define MM_P3_SER_TX 1
`define MM_P3_IRQ0 2
`define MM_P3_IRQ1 3
`define MM_P3_CNT0 4
`define MM_P3_CNT1 5
`define MM_P3_WR 6
`define MM_P3_RD 7

// ----------
// Timing
// ----------
`define MM_PHASE_CLKS 4
`define MM_PHASES_PER_MC 6
`define MM_RST_MCYC 2

`endif

// ### hdl/mc_timebase.v
/*
 * Divider that makes the bus phase enable and the machine cycle enable.
 * Assumes one free running clock; both enables are one-cycle pulses.
 */
`timescale 1ns/1ps

module mc_timebase #(
    parameter PHASE_CLKS = 4,
    parameter PHASES_PER_MC = 6
) (
    // Clock and reset
    input wire clk_sys,
    input wire arst_n,
    // Enables
    output reg phaseEn_r,
    output reg mcEn_r
);

reg [7:0] clkCnt_r;
reg [7:0] phaseCnt_r;

always @(posedge clk_sys or negedge arst_n)
begin
    if (!arst_n)
    begin
        clkCnt_r <= 8'h00;
        phaseCnt_r <= 8'h00;
        phaseEn_r <= 1'b0;
        mcEn_r <= 1'b0;
    end
    else
    begin
        phaseEn_r <= 1'b0;
        mcEn_r <= 1'b0;
        if (clkCnt_r == PHASE_CLKS[7:0] - 8'h01)
        begin
            clkCnt_r <= 8'h00;
            phaseEn_r <= 1'b1;
            if (phaseCnt_r == PHASES_PER_MC[7:0] - 8'h01)
            begin
                phaseCnt_r <= 8'h00;
                mcEn_r <= 1'b1;
            end
            else
            begin
                phaseCnt_r <= phaseCnt_r + 8'h01;
            end
        end
        else
        begin
            clkCnt_r <= clkCnt_r + 8'h01;
        end
    end
end

endmodule // mc_timebase

// ### hdl/mcu_memory_bus.v
/*
 * Memory map and external bus unit: reset pin filter, program fetch from
 * internal ROM or the external bus, external data moves, internal RAM and
 * special registers with bit access, port pins and alternate functions.
 * Assumes the core logic on clk_sys issues requests and an internal ROM
 * answers one cycle after its address.
 */
// Contract
// [RL1] Reset pin high two consecutive machine cycles resets the device.
// [RL2] Address latch strobe falls while the low address stands on port zero.
// [RL3] Program read strobe goes low for external code fetches.
// [RL4] Port zero is I/O, and multiplexed low address/data when external.
// [RL5] Port two is I/O, and carries the high address when external.
// [RL6] Port one is I/O; bit 6 is request-to-send, bit 7 clear-to-send.
// [RL7] Port three bits 0/1 serve receive, direction, transmit per link mode.
// [RL8] Clearing the port three bit 1 latch selects diagnostic mode.
// [RL9] Port three bits 2/3 are external interrupt or counter gate inputs.
// [RL10] Port three bit 4 counts counter zero; bit 5 serial clock or counter one.
// [RL11] External data uses port three bit 7 read and bit 6 write strobes.
// [RL12] Interrupt vectors sit eight bytes apart from 0003H to 0023H.
// [RL13] Program address space spans 0000H to FFFFH.
// [RL14] Fetch select sampled during reset picks internal ROM for 0000H-0FFFH.
// [RL15] External data uses the 16-bit pointer or an 8-bit register address.
// [RL16] Internal RAM holds 192 bytes, direct and indirect addressable.
// [RL17] Direct upper addresses hit special registers, indirect ones hit RAM.
// [RL18] Listed special registers are bit addressable at byte plus bit index.
// [RL19] RAM 20h-2Fh is bit addressable, bit 00h through 7Fh.
// [RL20] RAM 00h-1Fh holds four banks of eight registers.
// [RL21] Software may put code at a vector whose interrupt is disabled.
// [RL22] Bit address 80h up selects register at address with low bits cleared.
`timescale 1ns/1ps
`include "mcu_mem_defines.vh"

module mcu_memory_bus #(
    parameter RAM_BYTES = `MM_RAM_BYTES,
    parameter PHASE_CLKS = `MM_PHASE_CLKS,
    parameter PHASES_PER_MC = `MM_PHASES_PER_MC
) (
    // Clock and reset
    input wire clk_sys,
    input wire arst_n,
    // Control pins
    input wire resetPin,
    input wire extFetchSelectPin,
    output reg addrLatchEn_r,
    output reg progReadN_r,
    // Port pins, enable low while driving
    input wire [7:0] portZeroIn,
    output reg [7:0] portZeroOut_r,
    output reg [7:0] portZeroOeN_r,
    input wire [7:0] portOneIn,
    output reg [7:0] portOneOut_r,
    output reg [7:0] portOneOeN_r,
    input wire [7:0] portTwoIn,
    output reg [7:0] portTwoOut_r,
    output reg [7:0] portTwoOeN_r,
    input wire [7:0] portThreeIn,
    output reg [7:0] portThreeOut_r,
    output reg [7:0] portThreeOeN_r,
    // Device state
    output reg coreReset_r,
    output reg extFetchSel_r,
    output wire diagMode,
    // Code fetch
    input wire fetchReq,
    input wire [15:0] fetchAddr,
    output wire fetchReady,
    output reg fetchDone_r,
    output reg [7:0] fetchData_r,
    // Internal ROM
    output reg [11:0] romAddr_r,
    input wire [7:0] romRdData,
    // External data move
    input wire xReq,
    input wire xWrite,
    input wire xUsePtr,
    input wire [15:0] xPtrAddr,
    input wire [7:0] xRegAddr,
    input wire [7:0] xWrData,
    output wire xReady,
    output reg xDone_r,
    output reg [7:0] xRdData_r,
    // Internal memory access
    input wire imReq,
    input wire [1:0] imMode,
    input wire imWrite,
    input wire [7:0] imAddr,
    input wire [7:0] imWrData,
    output reg imDone_r,
    output reg [7:0] imRdData_r,
    // Vector lookup
    input wire [2:0] vecSel,
    output reg [15:0] vecAddr_r,
    // Serial unit and counters
    input wire serialLinkBidir,
    input wire serialTxOut,
    input wire serialRtsOut,
    output reg serialDataIn_r,
    output reg serialClkIn_r,
    output reg clearToSend_r,
    output reg extIrqZero_r,
    output reg extIrqOne_r,
    output reg counterZeroIn_r,
    output reg counterOneIn_r,
    // Hardware flag sets
    input wire [7:0] timerFlagSet,
    input wire [7:0] serialFlagSet,
    // Special register contents
    output wire [7:0] timerCtrl,
    output wire [7:0] irqEnable,
    output wire [7:0] irqPriority,
    output wire [7:0] serialStatus,
    output wire [7:0] serialCounts,
    output wire [7:0] programStatus,
    output wire [7:0] accumulator,
    output wire [7:0] mulDivAux
);

// ----------
// Decoders
// ----------
function [3:0] sfrIndex;
    input [7:0] a;
    begin
        case (a)
            `MM_SFR_PORT0: sfrIndex = 4'h0;
            `MM_SFR_TCTRL: sfrIndex = 4'h1;
            `MM_SFR_PORT1: sfrIndex = 4'h2;
            `MM_SFR_PORT2: sfrIndex = 4'h3;
            `MM_SFR_IRQEN: sfrIndex = 4'h4;
            `MM_SFR_PORT3: sfrIndex = 4'h5;
            `MM_SFR_IRQPRI: sfrIndex = 4'h6;
            `MM_SFR_SERST: sfrIndex = 4'h7;
            `MM_SFR_PSW: sfrIndex = 4'h8;
            `MM_SFR_SERCNT: sfrIndex = 4'h9;
            `MM_SFR_ACC: sfrIndex = 4'hA;
            `MM_SFR_AUXB: sfrIndex = 4'hB;
            default: sfrIndex = `MM_SFR_NONE;
        endcase
    end
endfunction

// [RL22] [RL18] [RL19] bit to byte
function [7:0] bitByte;
    input [7:0] b;
    begin
        if (b[`MM_SFR_AREA_BIT])
            bitByte = {b[7:3], 3'h0};
        else
            bitByte = `MM_BITRAM_BASE + {3'h0, b[7:3]};
    end
endfunction

// ----------
// Time base and pin synchronisers
// ----------
wire phaseEn;
wire mcEn;

mc_timebase #(
    .PHASE_CLKS(PHASE_CLKS),
    .PHASES_PER_MC(PHASES_PER_MC)
) timebase (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .phaseEn_r(phaseEn),
    .mcEn_r(mcEn)
);

reg [33:0] syncA_r;
reg [33:0] syncB_r;
wire [7:0] p0Pin = syncB_r[7:0];
wire [7:0] p1Pin = syncB_r[15:8];
wire [7:0] p2Pin = syncB_r[23:16];
wire [7:0] p3Pin = syncB_r[31:24];
wire rstPinS = syncB_r[32];
wire fetchSelS = syncB_r[33];

always @(posedge clk_sys or negedge arst_n)
begin
    if (!arst_n)
    begin
        syncA_r <= 34'h000000000;
        syncB_r <= 34'h000000000;
    end
    else
    begin
        syncA_r <= {extFetchSelectPin, resetPin, portThreeIn, portTwoIn, portOneIn, portZeroIn};
        syncB_r <= syncA_r;
    end
end

// ----------
// Reset filter and fetch select strap
// ----------
reg [1:0] rstCnt_r;

always @(posedge clk_sys or negedge arst_n)
begin
    if (!arst_n)
    begin
        rstCnt_r <= 2'h0;
        coreReset_r <= 1'b1;
        extFetchSel_r <= 1'b0;
    end
    else
    begin
        // [RL1] two machine cycles high
        if (!rstPinS)
        begin
            rstCnt_r <= 2'h0;
            coreReset_r <= 1'b0;
        end
        else if (mcEn && rstCnt_r != `MM_RST_MCYC)
            rstCnt_r <= rstCnt_r + 2'h1;
        else if (rstCnt_r == `MM_RST_MCYC)
            coreReset_r <= 1'b1;
        // [RL14] strap caught while in reset
        if (coreReset_r)
            extFetchSel_r <= fetchSelS;
    end
end

// ----------
// Special registers and internal RAM
// ----------
reg [7:0] sfrMem_r [0:`MM_SFR_COUNT-1];
reg [7:0] ram_r [0:RAM_BYTES-1];

assign timerCtrl = sfrMem_r[1];
assign irqEnable = sfrMem_r[4];
assign irqPriority = sfrMem_r[6];
assign serialStatus = sfrMem_r[7];
assign programStatus = sfrMem_r[8];
assign serialCounts = sfrMem_r[9];
assign accumulator = sfrMem_r[10];
assign mulDivAux = sfrMem_r[11];
// [RL8] diagnostic on cleared latch
assign diagMode = ~sfrMem_r[5][`MM_P3_SER_TX];

reg [7:0] imByte;
reg imSfr;
reg [3:0] imIdx;
reg imRamHit;
reg [7:0] latchByte;
reg [7:0] readByte;
reg [7:0] bitWrByte;

always @*
begin
    // [RL20] bank register address
    case (imMode)
        `MM_IM_BIT: imByte = bitByte(imAddr);
        `MM_IM_BANKREG: imByte = {3'h0, sfrMem_r[8][`MM_PSW_BANK_HI:`MM_PSW_BANK_LO], imAddr[2:0]};
        default: imByte = imAddr;
    endcase
    // [RL17] direct upper half is special registers
    imSfr = imByte[`MM_SFR_AREA_BIT] && imMode != `MM_IM_INDIRECT;
    imIdx = sfrIndex(imByte);
    // [RL16] RAM range check
    imRamHit = !imSfr && ({24'h000000, imByte} < RAM_BYTES);
    latchByte = 8'h00;
    if (imSfr && imIdx != `MM_SFR_NONE)
        latchByte = sfrMem_r[imIdx];
    else if (imRamHit)
        latchByte = ram_r[imByte];
    readByte = latchByte;
    if (imSfr)
    begin
        case (imIdx)
            4'h0: readByte = p0Pin;
            4'h2: readByte = p1Pin;
            4'h3: readByte = p2Pin;
            4'h5: readByte = p3Pin;
            default: readByte = latchByte;
        endcase
    end
    bitWrByte = latchByte;
    bitWrByte[imAddr[2:0]] = imWrData[0];
end

wire imWrEn = imReq && imWrite && !coreReset_r;
wire [7:0] imWrVal = (imMode == `MM_IM_BIT) ? bitWrByte : imWrData;

always @(posedge clk_sys)
begin
    if (imWrEn && imRamHit)
        ram_r[imByte] <= imWrVal;
end

genvar g;
generate
    for (g = 0; g < `MM_SFR_COUNT; g = g + 1)
    begin : sfrRegs
        wire isPort = (g == 0) || (g == 2) || (g == 3) || (g == 5);
        wire hit = imWrEn && imSfr && imIdx == g;
        wire [7:0] setBits = (g == 1) ? timerFlagSet : (g == 7) ? serialFlagSet : 8'h00;
        always @(posedge clk_sys or negedge arst_n)
        begin
            if (!arst_n)
                sfrMem_r[g] <= isPort ? `MM_PORT_RESET : `MM_SFR_RESET;
            else if (coreReset_r)
                sfrMem_r[g] <= isPort ? `MM_PORT_RESET : `MM_SFR_RESET;
            else
                sfrMem_r[g] <= (hit ? imWrVal : sfrMem_r[g]) | setBits;
        end
    end
endgenerate

always @(posedge clk_sys or negedge arst_n)
begin
    if (!arst_n)
    begin
        imDone_r <= 1'b0;
        imRdData_r <= 8'h00;
        vecAddr_r <= `MM_VEC_BASE;
    end
    else
    begin
        imDone_r <= imReq && !coreReset_r;
        if (imReq && !imWrite)
            imRdData_r <= (imMode == `MM_IM_BIT) ? {7'h00, readByte[imAddr[2:0]]} : readByte;
        // [RL12] eight byte vector spacing
        if (vecSel <= `MM_VEC_LAST)
            vecAddr_r <= `MM_VEC_BASE + ({13'h0000, vecSel} << `MM_VEC_STRIDE_SHIFT);
    end
end

// ----------
// External bus sequencer
// ----------
localparam S_IDLE = 3'h0;
localparam S_ALE = 3'h1;
localparam S_ADDR = 3'h2;
localparam S_STROBE = 3'h3;
localparam S_HOLD = 3'h4;
localparam S_ROM = 3'h5;
localparam K_FETCH = 2'h0;
localparam K_READ = 2'h1;
localparam K_WRITE = 2'h2;

reg [2:0] state_r;
reg [1:0] kind_r;
reg [15:0] busAddr_r;
reg [7:0] busData_r;

assign fetchReady = state_r == S_IDLE && !coreReset_r;
assign xReady = fetchReady && !fetchReq;

// [RL13] full 16-bit program space
wire romHit = extFetchSel_r && fetchAddr <= `MM_ROM_TOP;

always @(posedge clk_sys or negedge arst_n)
begin
    if (!arst_n)
    begin
        state_r <= S_IDLE;
        kind_r <= K_FETCH;
        busAddr_r <= 16'h0000;
        busData_r <= 8'h00;
        romAddr_r <= 12'h000;
        fetchDone_r <= 1'b0;
        fetchData_r <= 8'h00;
        xDone_r <= 1'b0;
        xRdData_r <= 8'h00;
    end
    else
    begin
        fetchDone_r <= 1'b0;
        xDone_r <= 1'b0;
        if (coreReset_r)
            state_r <= S_IDLE;
        else
        begin
            case (state_r)
                S_IDLE:
                begin
                    if (fetchReq)
                    begin
                        kind_r <= K_FETCH;
                        busAddr_r <= fetchAddr;
                        romAddr_r <= fetchAddr[11:0];
                        // [RL14] internal ROM for the low 4K
                        state_r <= romHit ? S_ROM : S_ALE;
                    end
                    else if (xReq)
                    begin
                        kind_r <= xWrite ? K_WRITE : K_READ;
                        // [RL15] pointer or register indexed
                        busAddr_r <= xUsePtr ? xPtrAddr : {sfrMem_r[3], xRegAddr};
                        busData_r <= xWrData;
                        state_r <= S_ALE;
                    end
                end
                S_ROM:
                begin
                    fetchData_r <= romRdData;
                    fetchDone_r <= 1'b1;
                    state_r <= S_IDLE;
                end
                S_ALE:
                    if (phaseEn)
                        state_r <= S_ADDR;
                S_ADDR:
                    if (phaseEn)
                        state_r <= S_STROBE;
                S_STROBE:
                    if (phaseEn)
                    begin
                        busData_r <= (kind_r == K_WRITE) ? busData_r : p0Pin;
                        state_r <= S_HOLD;
                    end
                S_HOLD:
                    if (phaseEn)
                    begin
                        state_r <= S_IDLE;
                        fetchDone_r <= kind_r == K_FETCH;
                        xDone_r <= kind_r != K_FETCH;
                        fetchData_r <= (kind_r == K_FETCH) ? busData_r : fetchData_r;
                        xRdData_r <= (kind_r == K_READ) ? busData_r : xRdData_r;
                    end
                default:
                    state_r <= S_IDLE;
            endcase
        end
    end
end

// ----------
// Pin drive
// ----------
wire extAddrPhase = state_r == S_ALE || state_r == S_ADDR;
wire extActive = extAddrPhase || state_r == S_STROBE || state_r == S_HOLD;
wire strobe = state_r == S_STROBE;
reg [7:0] p0Nxt;
reg [7:0] p0OeNxt;
reg [7:0] p1Nxt;
reg [7:0] p2Nxt;
reg [7:0] p2OeNxt;
reg [7:0] p3Nxt;
reg [7:0] p3OeNxt;

always @*
begin
    // [RL4] port zero I/O or address/data
    p0Nxt = sfrMem_r[0];
    p0OeNxt = sfrMem_r[0];
    if (extAddrPhase)
    begin
        p0Nxt = busAddr_r[7:0];
        p0OeNxt = 8'h00;
    end
    else if (extActive && kind_r == K_WRITE)
    begin
        p0Nxt = busData_r;
        p0OeNxt = 8'h00;
    end
    else if (extActive)
        p0OeNxt = 8'hFF;
    // [RL6] request-to-send on bit 6
    p1Nxt = sfrMem_r[2];
    p1Nxt[`MM_P1_RTS] = sfrMem_r[2][`MM_P1_RTS] & serialRtsOut;
    // [RL5] high address on port two
    p2Nxt = extActive ? busAddr_r[15:8] : sfrMem_r[3];
    p2OeNxt = extActive ? 8'h00 : sfrMem_r[3];
    // [RL7] transmit data on bit 1
    p3Nxt = sfrMem_r[5];
    p3Nxt[`MM_P3_SER_TX] = sfrMem_r[5][`MM_P3_SER_TX] & serialTxOut;
    // [RL11] data strobes on bits 6 and 7
    p3Nxt[`MM_P3_WR] = sfrMem_r[5][`MM_P3_WR] & !(strobe && kind_r == K_WRITE);
    p3Nxt[`MM_P3_RD] = sfrMem_r[5][`MM_P3_RD] & !(strobe && kind_r == K_READ);
    p3OeNxt = p3Nxt;
    // [RL7] bit 0 steers bit 1 on a two-way link
    if (serialLinkBidir && !p3Pin[`MM_P3_SER_RX])
        p3OeNxt[`MM_P3_SER_TX] = 1'b1;
end

always @(posedge clk_sys or negedge arst_n)
begin
    if (!arst_n)
    begin
        addrLatchEn_r <= 1'b0;
        progReadN_r <= 1'b1;
        portZeroOut_r <= `MM_PORT_RESET;
        portZeroOeN_r <= 8'hFF;
        portOneOut_r <= `MM_PORT_RESET;
        portOneOeN_r <= 8'hFF;
        portTwoOut_r <= `MM_PORT_RESET;
        portTwoOeN_r <= 8'hFF;
        portThreeOut_r <= `MM_PORT_RESET;
        portThreeOeN_r <= 8'hFF;
        serialDataIn_r <= 1'b0;
        serialClkIn_r <= 1'b0;
        clearToSend_r <= 1'b0;
        extIrqZero_r <= 1'b0;
        extIrqOne_r <= 1'b0;
        counterZeroIn_r <= 1'b0;
        counterOneIn_r <= 1'b0;
    end
    else
    begin
        // [RL2] high in first phase, falls with address held
        addrLatchEn_r <= state_r == S_ALE;
        // [RL3] low for external code fetch
        progReadN_r <= !(strobe && kind_r == K_FETCH);
        portZeroOut_r <= p0Nxt;
        portZeroOeN_r <= p0OeNxt;
        portOneOut_r <= p1Nxt;
        portOneOeN_r <= p1Nxt;
        portTwoOut_r <= p2Nxt;
        portTwoOeN_r <= p2OeNxt;
        portThreeOut_r <= p3Nxt;
        portThreeOeN_r <= p3OeNxt;
        // [RL7] receive from bit 0, or bit 1 when two-way
        serialDataIn_r <= serialLinkBidir ? p3Pin[`MM_P3_SER_TX] : p3Pin[`MM_P3_SER_RX];
        // [RL6] clear-to-send on bit 7
        clearToSend_r <= p1Pin[`MM_P1_CTS];
        // [RL9] interrupt or gate inputs
        extIrqZero_r <= p3Pin[`MM_P3_IRQ0];
        extIrqOne_r <= p3Pin[`MM_P3_IRQ1];
        // [RL10] counter and serial clock inputs
        counterZeroIn_r <= p3Pin[`MM_P3_CNT0];
        counterOneIn_r <= p3Pin[`MM_P3_CNT1];
        serialClkIn_r <= p3Pin[`MM_P3_CNT1];
    end
end

endmodule // mcu_memory_bus

// ### dv/mcu_memory_bus_assertions.sv
/* Port checks of the memory bus unit.
   Assumes binding into the bus unit, one clock domain. */
`timescale 1ns/1ps
module mcu_memory_bus_assertions #(
    parameter RAM_BYTES = 192,
    parameter PHASE_CLKS = 4,
    parameter PHASES_PER_MC = 6
) (
    // Clock, reset, pins
    input wire clk_sys,
    input wire arst_n,
    input wire resetPin,
    input wire addrLatchEn_r,
    input wire progReadN_r,
    input wire [7:0] portZeroOut_r,
    input wire [7:0] portZeroOeN_r,
    input wire [7:0] portThreeOut_r,
    // Core side
    input wire coreReset_r,
    input wire extFetchSel_r,
    input wire fetchReq,
    input wire [15:0] fetchAddr,
    input wire fetchReady,
    input wire fetchDone_r,
    input wire xReq,
    input wire xWrite,
    input wire xReady,
    input wire imReq,
    input wire imDone_r,
    input wire [2:0] vecSel,
    input wire [15:0] vecAddr_r
);
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    reg [7:0] hiCnt_r;
    wire romHit = fetchReq && fetchReady && extFetchSel_r && fetchAddr <= 16'h0FFF;
    wire extHit = fetchReq && fetchReady && !romHit;
    // Consecutive cycles of reset pin high
    always @(posedge clk_sys)
        hiCnt_r <= !resetPin ? 8'h00 : hiCnt_r + {7'h00, hiCnt_r != 8'hFF};
    a_ale_addr_out: assert property (addrLatchEn_r |-> portZeroOeN_r == 8'h00)
        else $error("low address not driven");
    a_ale_fall_hold: assert property ($fell(addrLatchEn_r) |-> $stable(portZeroOut_r))
        else $error("address moved at strobe fall");
    a_strobes_apart: assert property (!progReadN_r |-> &portThreeOut_r[7:6])
        else $error("data strobe during fetch");
    a_reset_blocks: assert property (coreReset_r |-> !fetchReady && !xReady)
        else $error("request taken in reset");
    a_reset_filter: assert property ($rose(coreReset_r) |-> $past(hiCnt_r, 4) >= PHASE_CLKS * PHASES_PER_MC - 2)
        else $error("reset on short pulse");
    a_rom_quiet: assert property (romHit |=> progReadN_r [*3])
        else $error("strobe on internal fetch");
    a_rom_answer: assert property (romHit |-> ##[1:3] fetchDone_r)
        else $error("internal fetch late");
    a_ext_strobe: assert property (extHit |-> ##[2:16] !progReadN_r)
        else $error("no program strobe");
    a_xread_strobe: assert property (xReq && xReady && !fetchReq && !xWrite |-> ##[2:16] !portThreeOut_r[7])
        else $error("no data read strobe");
    a_im_answer: assert property (imReq && !coreReset_r |=> imDone_r)
        else $error("internal access late");
    a_vec_step: assert property (vecSel <= 3'h4 |=> vecAddr_r == 16'h0003 + {$past(vecSel), 3'h0})
        else $error("vector address wrong");
    cover property (romHit);
    cover property (extHit);
    cover property (!portThreeOut_r[6]);
endmodule // mcu_memory_bus_assertions

bind mcu_memory_bus mcu_memory_bus_assertions #(
    .RAM_BYTES(RAM_BYTES),
    .PHASE_CLKS(PHASE_CLKS),
    .PHASES_PER_MC(PHASES_PER_MC)
) i_mcu_memory_bus_assertions (.*);

// ### dv/ext_mem_model.sv
/* External program and data memory on the multiplexed bus.
   Assumes the registered strobes and ports of the bus unit. */
`timescale 1ns/1ps
module ext_mem_model (
    // Clock and strobes
    input wire logic clk_sys,
    input wire logic addrLatchEn_r,
    input wire logic progReadN_r,
    // Ports
    input wire logic [7:0] portZeroOut_r,
    input wire logic [7:0] portZeroOeN_r,
    input wire logic [7:0] portTwoOut_r,
    input wire logic [7:0] portThreeOut_r,
    output logic [7:0] portZeroIn
);
    logic [7:0] lowAddr_r;
    logic [7:0] lastBus_r = 8'h00;
    logic [7:0] mem [0:255];
    always @(posedge clk_sys)
    begin
        if (addrLatchEn_r)
            lowAddr_r <= portZeroOut_r;
        if (!portThreeOut_r[6])
            mem[lowAddr_r] <= portZeroOut_r;
        lastBus_r <= portZeroIn;
    end
    // Released bus toggles each cycle
    always_comb
        if (!progReadN_r)
            portZeroIn = lowAddr_r ^ portTwoOut_r ^ 8'h5A;
        else if (!portThreeOut_r[7])
            portZeroIn = mem[lowAddr_r];
        else
            portZeroIn = (~portZeroOeN_r & portZeroOut_r) | (portZeroOeN_r & ~lastBus_r);
endmodule // ext_mem_model

// ### dv/mcu_memory_map_and_bus_pins_test.sv
/* Self-checking bench of the memory bus unit.
   Assumes ext_mem_model on the bus and pull-ups on ports 1 to 3. */
`timescale 1ns/1ps
module mcu_memory_map_and_bus_pins_test;
logic clk_sys = 0, arst_n = 0, resetPin = 0, extFetchSelectPin = 1, fetchReq = 0, xReq = 0, xWrite = 0;
logic xUsePtr = 0, imReq = 0, imWrite = 0, serialLinkBidir = 0, serialTxOut = 1, serialRtsOut = 1;
logic [1:0] imMode = 0;
logic [2:0] vecSel = 0;
logic [7:0] xRegAddr = 0, xWrData = 0, imAddr = 0, imWrData = 0, pinDrv = 8'hFF, timerFlagSet = 0;
logic [7:0] serialFlagSet = 0, romRdData, portZeroIn, portOneIn, portTwoIn, portThreeIn;
logic [15:0] fetchAddr = 0, xPtrAddr = 0, vecAddr_r;
logic addrLatchEn_r, progReadN_r, coreReset_r, extFetchSel_r, diagMode, fetchReady, fetchDone_r, xReady;
logic xDone_r, imDone_r, serialDataIn_r, serialClkIn_r, clearToSend_r, extIrqZero_r, extIrqOne_r;
logic counterZeroIn_r, counterOneIn_r;
logic [7:0] portZeroOut_r, portZeroOeN_r, portOneOut_r, portOneOeN_r, portTwoOut_r, portTwoOeN_r;
logic [7:0] portThreeOut_r, portThreeOeN_r, fetchData_r, xRdData_r, imRdData_r, timerCtrl, irqEnable;
logic [7:0] irqPriority, serialStatus, serialCounts, programStatus, accumulator, mulDivAux;
logic [11:0] romAddr_r;
int miscompares = 0, testsRun = 0, cyc = 0;
assign portOneIn = pinDrv & (portOneOeN_r | portOneOut_r);
assign portTwoIn = portTwoOeN_r | portTwoOut_r;
assign portThreeIn = pinDrv & (portThreeOeN_r | portThreeOut_r);
assign romRdData = romAddr_r[7:0] ^ 8'hC3;
always #5 clk_sys = ~clk_sys;
mcu_memory_bus #(.PHASES_PER_MC(2)) i_mcu_memory_bus (.*);
ext_mem_model i_ext_mem_model (.*);
// ---
// Shared tasks
// ---
task close_out;
    $display("checks %0d errors %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0)
        $display("[ PASS ]");
    else
        $display("[ FAIL ]");
    $finish;
endtask
task chk(input logic [15:0] got, exp);
    testsRun++;
    if (got !== exp)
    begin
        miscompares++;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task im(input logic [1:0] m, input logic w, input logic [7:0] a, d);
    @(posedge clk_sys);
    imReq <= 1'h1;
    imMode <= m;
    imWrite <= w;
    imAddr <= a;
    imWrData <= d;
    @(posedge clk_sys);
    imReq <= 1'h0;
    @(negedge clk_sys);
    chk(imDone_r, 1'h1);
endtask
task xfer(input logic f, w, p, input logic [15:0] a, input logic [7:0] d, e);
    repeat (60) if (fetchReady !== 1'h1) @(negedge clk_sys);
    @(posedge clk_sys);
    fetchReq <= f;
    fetchAddr <= a;
    xReq <= !f;
    xWrite <= w;
    xUsePtr <= p;
    xPtrAddr <= a;
    xRegAddr <= a[7:0];
    xWrData <= d;
    @(posedge clk_sys);
    fetchReq <= 1'h0;
    xReq <= 1'h0;
    repeat (60) if ((fetchDone_r | xDone_r) !== 1'h1) @(negedge clk_sys);
    chk(fetchDone_r | xDone_r, 1'h1);
    if (!w)
        chk(f ? fetchData_r : xRdData_r, e);
endtask
// ---
// Scenarios
// ---
task t_reset(input logic s);
    @(posedge clk_sys);
    resetPin <= 1'h1;
    extFetchSelectPin <= s;
    repeat (40) @(posedge clk_sys);
    resetPin <= 1'h0;
    repeat (6) @(posedge clk_sys);
    chk(coreReset_r, 1'h0);
    chk(extFetchSel_r, s);
    extFetchSelectPin <= !s;
    resetPin <= 1'h1;
    repeat (4) @(posedge clk_sys);
    resetPin <= 1'h0;
    repeat (6) @(posedge clk_sys);
    chk(coreReset_r, 1'h0);
    chk(extFetchSel_r, s);
endtask
task t_mem;
    im(2'h0, 1'h1, 8'hE0, 8'h3C);
    chk(accumulator, 8'h3C);
    im(2'h1, 1'h1, 8'hB8, 8'h99);
    chk(irqPriority, 8'h00);
    im(2'h1, 1'h0, 8'hB8, 8'h00);
    chk(imRdData_r, 8'h99);
    im(2'h1, 1'h0, 8'hC0, 8'h00);
    chk(imRdData_r, 8'h00);
    im(2'h0, 1'h1, 8'h2F, 8'h00);
    im(2'h2, 1'h1, 8'h7F, 8'h01);
    im(2'h0, 1'h0, 8'h2F, 8'h00);
    chk(imRdData_r, 8'h80);
    im(2'h2, 1'h1, 8'hE1, 8'h01);
    chk(accumulator, 8'h3E);
    im(2'h0, 1'h1, 8'hD0, 8'h10);
    im(2'h3, 1'h1, 8'h05, 8'hA7);
    im(2'h1, 1'h0, 8'h15, 8'h00);
    chk(imRdData_r, 8'hA7);
    im(2'h2, 1'h1, 8'hB1, 8'h00);
    chk(diagMode, 1'h1);
    im(2'h2, 1'h1, 8'hB1, 8'h01);
    chk(diagMode, 1'h0);
endtask
task t_vec_pins;
    for (int i = 0; i < 8; i++)
    begin
        @(posedge clk_sys);
        vecSel <= i[2:0];
        pinDrv <= 8'hFF ^ (8'h01 << i);
        serialRtsOut <= i[0];
        serialTxOut <= !i[1];
        serialLinkBidir <= i == 1;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(vecAddr_r, i < 5 ? 16'h0003 + 16'(i * 8) : 16'h0023);
        chk({portOneOut_r[6], portThreeOut_r[1]}, {i[0], !i[1]});
        chk({clearToSend_r, serialClkIn_r, counterOneIn_r, counterZeroIn_r, extIrqOne_r, extIrqZero_r, 1'h1,
            serialDataIn_r}, {pinDrv[7], pinDrv[5], pinDrv[5:2], 1'h1,
            serialLinkBidir ? pinDrv[1] : pinDrv[0]});
    end
endtask
always @(posedge clk_sys)
begin
    cyc++;
    if (cyc == 5000)
    begin
        miscompares++;
        close_out;
    end
end
initial
begin
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'h1;
    t_reset(1'h1);
    xfer(1'h1, 1'h0, 1'h0, 16'h000B, 8'h00, 8'hC8);
    xfer(1'h1, 1'h0, 1'h0, 16'h1234, 8'h00, 8'h7C);
    xfer(1'h0, 1'h1, 1'h1, 16'hAB55, 8'h66, 8'h00);
    xfer(1'h0, 1'h0, 1'h0, 16'h0055, 8'h00, 8'h66);
    t_reset(1'h0);
    xfer(1'h1, 1'h0, 1'h0, 16'h0123, 8'h00, 8'h78);
    xfer(1'h1, 1'h0, 1'h0, 16'hFFFF, 8'h00, 8'h5A);
    t_mem;
    t_vec_pins;
    close_out;
end
endmodule // mcu_memory_map_and_bus_pins_test
